//--- gcir_cfg.svh
// Offsets, field positions, reset values and timing of the global control register group.
`ifndef GCIR_CFG_SVH
`define GCIR_CFG_SVH

// ==========================================================
// Byte offsets on the management interface
`define GCIR_OFF_ID0 16'h0000
`define GCIR_OFF_ID1 16'h0001
`define GCIR_OFF_ID2 16'h0002
`define GCIR_OFF_REV 16'h0003
`define GCIR_OFF_WAKE 16'h0006
`define GCIR_OFF_GSTAT 16'h0010
`define GCIR_OFF_GMASK 16'h0014
`define GCIR_OFF_PSTAT 16'h0018
`define GCIR_OFF_PMASK 16'h001C
// Words are big-endian, so bit 31 lives at the word's first byte, bit 7.
`define GCIR_OFF_GSTAT_MSB 16'h0010
`define GCIR_OFF_GMASK_MSB 16'h0014
// Port bits 6:0 live in the word's last byte.
`define GCIR_OFF_PSTAT_LSB 16'h001B
`define GCIR_OFF_PMASK_LSB 16'h001F

// ==========================================================
// Field positions
`define GCIR_BIT_SRST 0
`define GCIR_REV_MSB 7
`define GCIR_REV_LSB 4
`define GCIR_BIT_WAKE_EN 1
`define GCIR_BIT_WAKE_POL 0
`define GCIR_BIT_LOOKUP 7

// ==========================================================
// Reset values
`define GCIR_RST_WAKE_EN 1'b0
`define GCIR_RST_WAKE_POL 1'b0
`define GCIR_RST_GMASK 1'b0
`define GCIR_RST_PMASK 7'h00
`define GCIR_RST_BYTE 8'h00

// ==========================================================
// Timing
`define GCIR_CLK_NS 8
`define GCIR_SRST_NS 128
`define GCIR_SRST_CYC ((`GCIR_SRST_NS + `GCIR_CLK_NS - 1) / `GCIR_CLK_NS)

`endif

//--- gcir_pkg.sv
// Types shared by the global control register group.
package gcir_pkg;
	typedef logic [15:0] gcir_addr_t;
	typedef logic [7:0] gcir_byte_t;
	typedef enum logic {
		GCIR_SR_IDLE,
		GCIR_SR_ACTIVE
	} gcir_srst_state_t;
endpackage

//--- gcir_regs.sv
// Global operation control and interrupt aggregation register group.
// Behaviour
// R1: Identification bytes at 0x0000..0x0002 are fixed and read-only, MSB at 0x0001.
// R2: Revision in byte 0x0003 bits 7:4; bits 3:1 reserved, read-only.
// R3: Writing one to 0x0003 bit 0 resets data path, keeps register contents.
// R4: Soft reset bit reads zero after reset and clears itself when done.
// R5: Byte 0x0006 bit 1 enables the wake event pin, default disabled.
// R6: Byte 0x0006 bit 0 picks wake pin polarity, default active low.
// R7: Word 0x0010 bit 31 mirrors the lookup engine request, other bits zero.
// R8: Word 0x0014 bit 31 masks the lookup engine interrupt, one disables.
// R9: Word 0x0018 bits 6:0 show per-port pending requests, read-only.
// R10: Word 0x001C bits 6:0 mask per-port interrupts, reset to zero.
// R11: Lookup status only reflects its sources; writes never clear it.
// R12: Multi-byte words are big-endian; every byte is accessed on its own.
// R13: Interrupt request is high while any unmasked status bit is one.
`timescale 1ns/1ps
`include "gcir_cfg.svh"

module gcir_regs #(
	parameter int unsigned NUM_PORTS = 7,
	parameter int unsigned SRST_CYCLES = `GCIR_SRST_CYC,
	parameter logic [7:0] CHIP_ID_B0 = 8'h11, // Arbitrary value.
	parameter logic [15:0] CHIP_ID = 16'h5A3C, // Arbitrary value.
	parameter logic [3:0] REV_ID = 4'h1 // Arbitrary value.
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire gcir_pkg::gcir_addr_t reg_addr,
	input wire logic reg_wr,
	input wire gcir_pkg::gcir_byte_t reg_wdata,
	input wire logic reg_rd,
	output gcir_pkg::gcir_byte_t reg_rdata,
	output logic reg_rvalid,
	input wire logic lookup_irq,
	input wire logic [6:0] port_irq,
	input wire logic wake_evt,
	output logic wake_out,
	output logic wake_oe,
	output logic datapath_rst,
	output logic irq_req
);
	import gcir_pkg::*;

	// ==========================================================
	// Elaboration checks
	// The port fields occupy exactly seven bits and the counter is eight bits wide.
	generate
		if (NUM_PORTS != 7) begin : g_bad_ports
			$error("NUM_PORTS must be 7");
		end
		if (SRST_CYCLES < 1 || SRST_CYCLES > 255) begin : g_bad_srst
			$error("SRST_CYCLES must be 1 to 255");
		end
	endgenerate

	localparam logic [7:0] SRST_LOAD = 8'(SRST_CYCLES);

	// ==========================================================
	// Address decode
	// One compare shared by the write and read paths keeps both maps in step.
	function automatic logic hit(input gcir_addr_t a, input gcir_addr_t off);
		hit = (a == off);
	endfunction

	// ==========================================================
	// Register state
	logic wake_en_reg, wake_en_next;
	logic wake_pol_reg, wake_pol_next;
	logic gmask_reg, gmask_next;
	logic [6:0] pmask_reg, pmask_next;
	logic gstat_reg, gstat_next;
	logic [6:0] pstat_reg, pstat_next;
	logic [6:0] port_pend;
	logic irq_next;
	logic wake_out_next, wake_oe_next;
	gcir_srst_state_t sr_state_reg, sr_state_next;
	logic [7:0] sr_cnt_reg, sr_cnt_next;
	gcir_byte_t rdata_next;
	logic rvalid_next;
	logic srst_wr;

	// A soft reset is requested by a one in bit 0 of the revision byte.
	assign srst_wr = reg_wr && hit(reg_addr, `GCIR_OFF_REV) && reg_wdata[`GCIR_BIT_SRST]; // R3

	// Per-port pending terms, one per port.
	generate
		for (genvar p = 0; p < 7; p++) begin : g_port
			assign port_pend[p] = pstat_reg[p] & ~pmask_reg[p]; // R13
		end
	endgenerate

	// ==========================================================
	// Control registers and status capture
	// Only the first lookup mask byte and the last port mask byte hold live bits; the reserved bytes ignore writes.
	always_comb begin
		wake_en_next = wake_en_reg;
		wake_pol_next = wake_pol_reg;
		gmask_next = gmask_reg;
		pmask_next = pmask_reg;
		if (reg_wr && hit(reg_addr, `GCIR_OFF_WAKE)) begin
			wake_en_next = reg_wdata[`GCIR_BIT_WAKE_EN]; // R5
			wake_pol_next = reg_wdata[`GCIR_BIT_WAKE_POL]; // R6
		end
		if (reg_wr && hit(reg_addr, `GCIR_OFF_GMASK_MSB)) begin
			gmask_next = reg_wdata[`GCIR_BIT_LOOKUP]; // R8 R12
		end
		if (reg_wr && hit(reg_addr, `GCIR_OFF_PMASK_LSB)) begin
			pmask_next = reg_wdata[6:0]; // R10 R12
		end
		// Status copies follow their sources; no write path exists, so writes cannot clear them.
		gstat_next = lookup_irq; // R7 R11
		pstat_next = port_irq; // R9
		irq_next = (gstat_reg & ~gmask_reg) | (|port_pend); // R13
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_en_reg <= `GCIR_RST_WAKE_EN;
			wake_pol_reg <= `GCIR_RST_WAKE_POL;
			gmask_reg <= `GCIR_RST_GMASK;
			pmask_reg <= `GCIR_RST_PMASK;
			gstat_reg <= 1'b0;
			pstat_reg <= 7'h00;
			irq_req <= 1'b0;
		end else begin
			wake_en_reg <= wake_en_next;
			wake_pol_reg <= wake_pol_next;
			gmask_reg <= gmask_next;
			pmask_reg <= pmask_next;
			gstat_reg <= gstat_next;
			pstat_reg <= pstat_next;
			irq_req <= irq_next;
		end
	end

	// ==========================================================
	// Soft reset sequencer
	// Register contents live outside this sequencer, so they survive the pulse.
	// A new request during the pulse restarts the count, so it is never lost.
	always_comb begin
		sr_state_next = sr_state_reg;
		sr_cnt_next = sr_cnt_reg;
		case (sr_state_reg)
			GCIR_SR_IDLE: begin
				if (srst_wr) begin
					sr_state_next = GCIR_SR_ACTIVE; // R3
					sr_cnt_next = SRST_LOAD;
				end
			end
			GCIR_SR_ACTIVE: begin
				if (srst_wr) begin
					sr_cnt_next = SRST_LOAD;
				end else if (sr_cnt_reg == 8'h01) begin
					sr_state_next = GCIR_SR_IDLE; // R4
					sr_cnt_next = 8'h00;
				end else begin
					sr_cnt_next = sr_cnt_reg - 8'h01;
				end
			end
			default: begin
				sr_state_next = GCIR_SR_IDLE;
				sr_cnt_next = 8'h00;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sr_state_reg <= GCIR_SR_IDLE;
			sr_cnt_reg <= 8'h00;
		end else begin
			sr_state_reg <= sr_state_next;
			sr_cnt_reg <= sr_cnt_next;
		end
	end

	// The data path is held in reset for as long as the bit reads one.
	assign datapath_rst = (sr_state_reg == GCIR_SR_ACTIVE); // R3

	// ==========================================================
	// Wake event pin
	// A disabled pin is released rather than driven to its idle level.
	always_comb begin
		wake_oe_next = wake_en_reg; // R5
		wake_out_next = wake_pol_reg ? wake_evt : ~wake_evt; // R6
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_oe <= 1'b0;
			wake_out <= 1'b1;
		end else begin
			wake_oe <= wake_oe_next;
			wake_out <= wake_out_next;
		end
	end

	// ==========================================================
	// Read path
	// One byte per request, answered one cycle later; unmapped bytes read zero.
	always_comb begin
		rdata_next = `GCIR_RST_BYTE;
		rvalid_next = reg_rd;
		if (reg_rd) begin
			if (hit(reg_addr, `GCIR_OFF_ID0)) begin
				rdata_next = CHIP_ID_B0; // R1
			end else if (hit(reg_addr, `GCIR_OFF_ID1)) begin
				rdata_next = CHIP_ID[15:8]; // R1 R12
			end else if (hit(reg_addr, `GCIR_OFF_ID2)) begin
				rdata_next = CHIP_ID[7:0]; // R1 R12
			end else if (hit(reg_addr, `GCIR_OFF_REV)) begin
				rdata_next = {REV_ID, 3'b000, datapath_rst}; // R2 R4
			end else if (hit(reg_addr, `GCIR_OFF_WAKE)) begin
				rdata_next = {6'b000000, wake_en_reg, wake_pol_reg}; // R5 R6
			end else if (hit(reg_addr, `GCIR_OFF_GSTAT_MSB)) begin
				rdata_next = {gstat_reg, 7'b0000000}; // R7 R12
			end else if (hit(reg_addr, `GCIR_OFF_GMASK_MSB)) begin
				rdata_next = {gmask_reg, 7'b0000000}; // R8
			end else if (hit(reg_addr, `GCIR_OFF_PSTAT_LSB)) begin
				rdata_next = {1'b0, pstat_reg}; // R9
			end else if (hit(reg_addr, `GCIR_OFF_PMASK_LSB)) begin
				rdata_next = {1'b0, pmask_reg}; // R10
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= `GCIR_RST_BYTE;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= rdata_next;
			reg_rvalid <= rvalid_next;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Identification and revision bytes are fixed.
	a_id_msb_read: assert property (reg_rd && reg_addr == `GCIR_OFF_ID1 // R1
		|=> reg_rvalid && reg_rdata == CHIP_ID[15:8])
		else $error("chip id msb wrong");
	a_rev_reserved: assert property (reg_rd && reg_addr == `GCIR_OFF_REV // R2
		|=> reg_rdata[7:4] == REV_ID && reg_rdata[3:1] == 3'b000)
		else $error("revision byte wrong");
	// Soft reset pulse, its length and its readback.
	a_srst_start: assert property (srst_wr |=> datapath_rst) // R3
		else $error("soft reset did not start");
	a_srst_clear: assert property (datapath_rst && sr_cnt_reg == 8'h01 && !srst_wr // R4
		|=> !datapath_rst)
		else $error("soft reset did not self clear");
	a_srst_hold: assert property (datapath_rst && sr_cnt_reg > 8'h01 // R3
		|=> datapath_rst)
		else $error("soft reset ended early");
	a_srst_readback: assert property (reg_rd && reg_addr == `GCIR_OFF_REV // R4
		|=> reg_rdata[`GCIR_BIT_SRST] == $past(datapath_rst))
		else $error("soft reset bit misread");
	a_srst_keep_mask: assert property (datapath_rst && !reg_wr // R3
		|=> $stable(pmask_reg) && $stable(wake_en_reg))
		else $error("soft reset disturbed registers");
	// Wake event pin drive and level.
	a_wake_disabled: assert property (!wake_en_reg |=> !wake_oe) // R5
		else $error("wake pin driven while disabled");
	a_wake_enabled: assert property (wake_en_reg |=> wake_oe) // R5
		else $error("wake pin not driven while enabled");
	a_wake_level: assert property (wake_oe // R6
		|-> wake_out == ($past(wake_pol_reg) ? $past(wake_evt) : ~$past(wake_evt)))
		else $error("wake polarity wrong");
	// Status copies, masks and the request they combine into.
	a_lookup_status: assert property (##1 reg_rd && reg_addr == `GCIR_OFF_GSTAT_MSB // R7 R11
		|=> reg_rdata == {$past(lookup_irq, 2), 7'b0000000})
		else $error("lookup status wrong");
	a_status_no_clear: assert property (reg_wr && reg_addr == `GCIR_OFF_GSTAT_MSB // R11
		|=> gstat_reg == $past(lookup_irq))
		else $error("lookup status cleared by write");
	a_gmask_write: assert property (reg_wr && reg_addr == `GCIR_OFF_GMASK_MSB // R8
		|=> gmask_reg == $past(reg_wdata[`GCIR_BIT_LOOKUP]))
		else $error("lookup mask not written");
	a_port_status: assert property (##1 reg_rd && reg_addr == `GCIR_OFF_PSTAT_LSB // R9
		|=> reg_rdata == {1'b0, $past(port_irq, 2)})
		else $error("port status wrong");
	a_pmask_write: assert property (reg_wr && reg_addr == `GCIR_OFF_PMASK_LSB // R10
		|=> pmask_reg == $past(reg_wdata[6:0]))
		else $error("port mask not written");
	a_pmask_hold: assert property (!(reg_wr && reg_addr == `GCIR_OFF_PMASK_LSB) // R10
		|=> $stable(pmask_reg))
		else $error("port mask changed without write");
	a_irq_unmasked: assert property (##2 1 // R13
		|-> irq_req == (($past(lookup_irq, 2) & ~$past(gmask_reg))
		| (|($past(port_irq, 2) & ~$past(pmask_reg)))))
		else $error("interrupt request wrong");
	// Read answers stand one cycle; unmapped bytes read zero.
	a_read_answer: assert property (reg_rd |=> reg_rvalid) // R12
		else $error("read not answered");
	a_idle_bus: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00) // R12
		else $error("answer without read");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 16'h0011 // R12
		|=> reg_rdata == 8'h00)
		else $error("reserved byte not zero");
endmodule

//--- test_gcir_regs.sv
// Self-checking testbench for the global control register group.
`timescale 1ns/1ps

module test_gcir_regs;
	import gcir_pkg::*;
	// ==========================================================
	// Set-up
	// A short soft-reset count keeps the run brief; expectations derive from it.
	localparam int unsigned SRST = 6;
	localparam logic [7:0] ID0 = 8'h11; // Arbitrary value.
	localparam logic [15:0] ID = 16'h5A3C; // Arbitrary value.
	localparam logic [3:0] REV = 4'h1; // Arbitrary value.
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	gcir_addr_t reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	gcir_byte_t reg_wdata = 8'h00;
	logic reg_rd = 1'b0;
	gcir_byte_t reg_rdata;
	logic reg_rvalid;
	logic lookup_irq = 1'b0;
	logic [6:0] port_irq = 7'h00;
	logic wake_evt = 1'b0;
	logic wake_out;
	logic wake_oe;
	logic datapath_rst;
	logic irq_req;
	int miscompares = 0;
	int tests_run = 0;

	// The clock toggles every 4 ns, half of its 8 ns period.
	always #4 core_clk = ~core_clk;

	gcir_regs #(.SRST_CYCLES(SRST), .CHIP_ID_B0(ID0), .CHIP_ID(ID), .REV_ID(REV)) dut (
		.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .lookup_irq(lookup_irq), .port_irq(port_irq),
		.wake_evt(wake_evt), .wake_out(wake_out), .wake_oe(wake_oe),
		.datapath_rst(datapath_rst), .irq_req(irq_req));

	// ==========================================================
	// Shared tasks
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_byte(input gcir_byte_t got, input gcir_byte_t exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s: got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Strobes rise and fall on falling edges, so each is seen by exactly one rising edge.
	task automatic wr(input gcir_addr_t a, input gcir_byte_t d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	// The answer stands for one cycle only, so it is judged at the next falling edge.
	task automatic rd(input gcir_addr_t a, input gcir_byte_t exp);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk_bit(reg_rvalid, 1'b1, "read answer");
		chk_byte(reg_rdata, exp, "read data");
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_reset_values();
		rd(16'h0000, ID0);
		rd(16'h0001, ID[15:8]);
		rd(16'h0002, ID[7:0]);
		rd(16'h0003, {REV, 4'h0});
		rd(16'h0006, 8'h00);
		rd(16'h0014, 8'h00);
		rd(16'h001F, 8'h00);
		chk_bit(wake_oe, 1'b0, "wake pin released");
		chk_bit(wake_out, 1'b1, "wake pin idle");
		chk_bit(datapath_rst, 1'b0, "soft reset idle");
		chk_bit(irq_req, 1'b0, "no request");
	endtask

	// Writes to fixed bytes must leave them alone; bits 7:1 of the revision byte too.
	task automatic test_ident_ro();
		wr(16'h0000, 8'hFF);
		wr(16'h0001, 8'hFF);
		wr(16'h0002, 8'hFF);
		wr(16'h0003, 8'hFE);
		rd(16'h0000, ID0);
		rd(16'h0001, ID[15:8]);
		rd(16'h0002, ID[7:0]);
		rd(16'h0003, {REV, 4'h0});
		chk_bit(datapath_rst, 1'b0, "no soft reset on zero");
	endtask

	task automatic test_soft_reset();
		int cnt;
		cnt = 0;
		wr(16'h0006, 8'h03);
		wr(16'h0003, 8'h01);
		chk_bit(datapath_rst, 1'b1, "soft reset started");
		rd(16'h0003, {REV, 4'h1});
		// Bounded count of the remaining high cycles; three have passed already.
		repeat (20) begin
			@(negedge core_clk);
			if (datapath_rst === 1'b1) begin
				cnt++;
			end
		end
		chk_byte(8'(cnt), 8'(SRST - 3), "soft reset length");
		rd(16'h0003, {REV, 4'h0});
		rd(16'h0006, 8'h03);
		chk_bit(wake_oe, 1'b1, "wake pin driven");
		// A second request inside the pulse reloads the count, so SRST less one high cycles remain.
		wr(16'h0003, 8'h01);
		wr(16'h0003, 8'h01);
		cnt = 0;
		repeat (20) begin
			@(negedge core_clk);
			if (datapath_rst === 1'b1) begin
				cnt++;
			end
		end
		chk_byte(8'(cnt), 8'(SRST - 1), "restarted length");
	endtask

	task automatic test_wake_pin();
		chk_bit(wake_out, 1'b0, "active high idle");
		wake_evt = 1'b1;
		tick(2);
		chk_bit(wake_out, 1'b1, "active high event");
		wr(16'h0006, 8'h02);
		tick(1);
		chk_bit(wake_out, 1'b0, "active low event");
		wake_evt = 1'b0;
		tick(2);
		chk_bit(wake_out, 1'b1, "active low idle");
		wr(16'h0006, 8'hFC);
		rd(16'h0006, 8'h00);
		tick(1);
		chk_bit(wake_oe, 1'b0, "wake pin released");
	endtask

	task automatic test_lookup_irq();
		lookup_irq = 1'b1;
		tick(3);
		chk_bit(irq_req, 1'b1, "lookup request");
		rd(16'h0010, 8'h80);
		rd(16'h0013, 8'h00);
		wr(16'h0010, 8'h00);
		rd(16'h0010, 8'h80);
		wr(16'h0014, 8'hFF);
		rd(16'h0014, 8'h80);
		tick(2);
		chk_bit(irq_req, 1'b0, "lookup masked");
		lookup_irq = 1'b0;
		tick(3);
		rd(16'h0010, 8'h00);
		wr(16'h0014, 8'h00);
		tick(3);
		chk_bit(irq_req, 1'b0, "nothing pending");
	endtask

	// Each port in turn: pending, masked by its own bit, not masked by the others.
	task automatic test_port_irq();
		for (int n = 0; n < 7; n++) begin
			port_irq = 7'(1 << n);
			tick(3);
			chk_bit(irq_req, 1'b1, "port request");
			rd(16'h001B, 8'(1 << n));
			wr(16'h001F, 8'(1 << n));
			tick(2);
			chk_bit(irq_req, 1'b0, "port masked");
			rd(16'h001F, 8'(1 << n));
			wr(16'h001F, 8'h7F ^ 8'(1 << n));
			tick(2);
			chk_bit(irq_req, 1'b1, "other masks");
			wr(16'h001F, 8'h00);
		end
		port_irq = 7'h00;
		rd(16'h0018, 8'h00);
		wr(16'h001F, 8'hFF);
		rd(16'h001F, 8'h7F);
		rd(16'h001C, 8'h00);
	endtask

	task automatic test_unmapped();
		wr(16'h0004, 8'hFF);
		rd(16'h0004, 8'h00);
		rd(16'h0011, 8'h00);
		rd(16'h0020, 8'h00);
		// A non-zero answer first, so the return to zero is really seen.
		rd(16'h0001, ID[15:8]);
		tick(1);
		chk_byte(reg_rdata, 8'h00, "data after answer");
		chk_bit(reg_rvalid, 1'b0, "answer lasts one cycle");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(negedge core_clk);
		rst_b = 1'b1;
		test_reset_values();
		test_ident_ro();
		test_soft_reset();
		test_wake_pin();
		test_lookup_irq();
		test_port_irq();
		test_unmapped();
		conclude();
	end
endmodule
